// >>> design/pde_map.svh
// Register offsets, field positions and reset values of the port D/E block
`ifndef PDE_MAP_SVH
`define PDE_MAP_SVH
// ==========================================================
// Byte offsets on the register bus (word index times four)
`define PDE_OFF_D_PIN 6'h00
`define PDE_OFF_D_LAT 6'h04
`define PDE_OFF_D_DIR 6'h08
`define PDE_OFF_E_DIR 6'h0C
`define PDE_OFF_E_PIN 6'h10
`define PDE_OFF_E_LAT 6'h14
`define PDE_OFF_ANSEL 6'h18
// ==========================================================
// Fields of the port E direction and slave status register
`define PDE_BIT_IN_FULL 7
`define PDE_BIT_OUT_FULL 6
`define PDE_BIT_OVERRUN 5
`define PDE_BIT_SLAVE_MODE 4
// ==========================================================
// Reset values
`define PDE_RST_D_DIR 8'hFF
`define PDE_RST_E_DIR 3'h7
`define PDE_RST_ANSEL 7'h7F
`define PDE_RST_LAT 8'h00
`endif

// >>> design/pde_pkg.sv
// Types shared by the port D/E block
package pde_pkg;
  // ==========================================================
  // Parallel slave strobe tracker states
  typedef enum logic [2:0] {
    PDE_SL_IDLE = 3'b001,
    PDE_SL_WR = 3'b010,
    PDE_SL_RD = 3'b100
  } pde_slave_state_t;
endpackage

// >>> design/pde_sync_if.sv
// Interface carrying raw and synchronised pin levels
`timescale 1ns/1ps
interface pde_sync_if;
  logic [11:0] raw;
  logic [11:0] synced;
  modport src (output raw, input synced);
  modport snk (input raw, output synced);
endinterface

// >>> design/pde_sync.sv
// Two-flop synchroniser for pin inputs
`timescale 1ns/1ps
module pde_sync #(
  parameter int WIDTH = 12
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst_b,
  // Pin levels
  pde_sync_if.snk sif
);
  typedef struct packed {
    logic [WIDTH-1:0] stage1;
    logic [WIDTH-1:0] stage2;
  } pde_sync_st_t;
  pde_sync_st_t st_reg;
  pde_sync_st_t st_next;
  // First stage feeds only the second
  always_comb begin
    st_next = st_reg;
    st_next.stage1 = sif.raw;
    st_next.stage2 = st_reg.stage1;
  end
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end
  assign sif.synced = st_reg.stage2;
endmodule

// >>> design/pde_slave.sv
// Parallel slave strobe tracker: detects write and read windows
`timescale 1ns/1ps
module pde_slave (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst_b,
  // Enable (active high) and synchronised strobes, active low
  input wire logic enable,
  input wire logic cs_n,
  input wire logic wr_n,
  input wire logic rd_n,
  // Events
  output logic wr_start,
  output logic wr_end,
  output logic rd_start,
  output logic rd_end,
  output logic reading
);
  typedef struct packed {
    pde_pkg::pde_slave_state_t state;
  } pde_slave_st_t;
  pde_slave_st_t st_reg;
  pde_slave_st_t st_next;
  // Window opens on both lows, closes on either high
  always_comb begin
    st_next = st_reg;
    wr_start = 1'b0;
    wr_end = 1'b0;
    rd_start = 1'b0;
    rd_end = 1'b0;
    case (st_reg.state)
      pde_pkg::PDE_SL_IDLE: begin
        if (enable && !cs_n && !wr_n) begin
          st_next.state = pde_pkg::PDE_SL_WR;
          wr_start = 1'b1;
        end else if (enable && !cs_n && !rd_n) begin
          st_next.state = pde_pkg::PDE_SL_RD;
          rd_start = 1'b1;
        end
      end
      pde_pkg::PDE_SL_WR: begin
        if (cs_n || wr_n || !enable) begin
          st_next.state = pde_pkg::PDE_SL_IDLE;
          wr_end = 1'b1;
        end
      end
      pde_pkg::PDE_SL_RD: begin
        if (cs_n || rd_n || !enable) begin
          st_next.state = pde_pkg::PDE_SL_IDLE;
          rd_end = 1'b1;
        end
      end
      default: begin
        st_next.state = pde_pkg::PDE_SL_IDLE;
      end
    endcase
  end
  assign reading = (st_reg.state == pde_pkg::PDE_SL_RD);
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      st_reg.state <= pde_pkg::PDE_SL_IDLE;
    end else begin
      st_reg <= st_next;
    end
  end
endmodule

// >>> design/pde_port.sv
// Port D and port E general I/O with parallel slave port, Avalon-MM registers
//
// The implementer's own choices: register access over Avalon-MM and the register addresses.
`timescale 1ns/1ps
`include "pde_map.svh"
module pde_port #(
  parameter bit SMALL_PACKAGE = 1'b0
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst_b,
  // Avalon-MM slave
  input wire logic [5:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // Port D pins
  input wire logic [7:0] port_d_in,
  output logic [7:0] port_d_out,
  output logic [7:0] port_d_oe,
  // Port E pins
  input wire logic [2:0] port_e_in,
  output logic [2:0] port_e_out,
  output logic [2:0] port_e_oe,
  input wire logic input_only_pin,
  // Configuration and peripheral overrides
  input wire logic external_reset_pin_enable,
  input wire logic pwm_multi_output,
  input wire logic [3:0] pwm_out_en,
  input wire logic [3:0] pwm_out,
  input wire logic capture_compare_out_en,
  input wire logic capture_compare_out,
  input wire logic [1:0] comparator_out_en,
  input wire logic [1:0] comparator_out,
  // Status outputs
  output logic slave_port_interrupt_flag,
  output logic [7:0] port_d_digital_in,
  output logic external_reset_input
);
  typedef struct packed {
    logic [7:0] d_lat;
    logic [7:0] d_dir;
    logic [2:0] e_lat;
    logic [2:0] e_dir;
    logic slave_mode;
    logic in_full;
    logic out_full;
    logic overrun;
    logic [6:0] ansel;
    logic [7:0] slave_in;
    logic flag;
    logic ack;
    logic [31:0] rdata;
    logic [7:0] d_out;
    logic [7:0] d_oe;
    logic [2:0] e_out;
    logic [2:0] e_oe;
    logic [7:0] d_dig;
    logic ext_rst;
  } pde_port_st_t;
  pde_port_st_t st_reg;
  pde_port_st_t st_next;
  // ==========================================================
  // Pin synchronisers
  pde_sync_if sif ();
  assign sif.raw = {input_only_pin, port_e_in, port_d_in};
  pde_sync #(
    .WIDTH(12)
  ) u_sync (
    .sys_clk(sys_clk),
    .rst_b(rst_b),
    .sif(sif)
  );
  logic [7:0] d_sync;
  logic [2:0] e_sync;
  logic re3_sync;
  assign d_sync = sif.synced[7:0];
  assign e_sync = sif.synced[10:8];
  assign re3_sync = sif.synced[11];
  // ==========================================================
  // Parallel slave port
  logic slave_active;
  logic wr_start;
  logic wr_end;
  logic rd_start;
  logic rd_end;
  logic reading;
  // Multi-output PWM owns port D, so it wins over the mode bit
  assign slave_active = st_reg.slave_mode && !pwm_multi_output && !SMALL_PACKAGE;
  pde_slave u_slave (
    .sys_clk(sys_clk),
    .rst_b(rst_b),
    .enable(slave_active),
    .cs_n(e_sync[2]),
    .wr_n(e_sync[1]),
    .rd_n(e_sync[0]),
    .wr_start(wr_start),
    .wr_end(wr_end),
    .rd_start(rd_start),
    .rd_end(rd_end),
    .reading(reading)
  );
  // Byte lane 0 write helper
  function automatic logic [7:0] merge_byte(input logic [7:0] old, input logic [31:0] wd,
                                            input logic [3:0] be);
    merge_byte = be[0] ? wd[7:0] : old;
  endfunction
  // ==========================================================
  // Register file, slave events and pin drive
  logic acc;
  logic [7:0] d_rd;
  logic [2:0] e_rd;
  assign acc = (avs_read || avs_write) && !st_reg.ack;
  // Analog pins read as zero
  assign d_rd = d_sync & ~{4'h0, st_reg.ansel[3:0]};
  assign e_rd = e_sync & ~st_reg.ansel[6:4];
  always_comb begin
    st_next = st_reg;
    st_next.ack = acc;
    st_next.rdata = 32'h0000_0000;
    st_next.flag = 1'b0;
    if (acc && avs_read) begin
      case (avs_address)
        `PDE_OFF_D_PIN: st_next.rdata = {24'h00_0000, d_rd};
        `PDE_OFF_D_LAT: st_next.rdata = {24'h00_0000, st_reg.d_lat};
        `PDE_OFF_D_DIR: st_next.rdata = {24'h00_0000, st_reg.d_dir};
        `PDE_OFF_E_DIR: begin
          st_next.rdata = {24'h00_0000, st_reg.in_full, st_reg.out_full, st_reg.overrun,
                           st_reg.slave_mode, 1'b0, st_reg.e_dir};
        end
        `PDE_OFF_E_PIN: begin
          // Input-only pin reads only when not the reset input
          st_next.rdata = {28'h000_0000, re3_sync & !external_reset_pin_enable,
                           SMALL_PACKAGE ? 3'h0 : e_rd};
        end
        `PDE_OFF_E_LAT: st_next.rdata = {29'h0000_0000, st_reg.e_lat};
        `PDE_OFF_ANSEL: st_next.rdata = {25'h000_0000, st_reg.ansel};
        default: st_next.rdata = 32'h0000_0000;
      endcase
      // CPU reading the received word clears input full
      if (avs_address == `PDE_OFF_D_PIN && slave_active) begin
        st_next.rdata = {24'h00_0000, st_reg.slave_in};
        st_next.in_full = 1'b0;
      end
    end
    if (acc && avs_write) begin
      case (avs_address)
        `PDE_OFF_D_PIN, `PDE_OFF_D_LAT: begin
          st_next.d_lat = merge_byte(st_reg.d_lat, avs_writedata, avs_byteenable);
          if (slave_active && avs_byteenable[0] && !reading) begin
            st_next.out_full = 1'b1;
          end
        end
        `PDE_OFF_D_DIR: begin
          st_next.d_dir = merge_byte(st_reg.d_dir, avs_writedata, avs_byteenable);
        end
        `PDE_OFF_E_DIR: begin
          if (avs_byteenable[0]) begin
            st_next.e_dir = avs_writedata[2:0];
            st_next.slave_mode = avs_writedata[`PDE_BIT_SLAVE_MODE];
            // Writing zero clears overrun
            if (!avs_writedata[`PDE_BIT_OVERRUN]) begin
              st_next.overrun = 1'b0;
            end
          end
        end
        `PDE_OFF_E_PIN, `PDE_OFF_E_LAT: begin
          if (avs_byteenable[0]) begin
            st_next.e_lat = avs_writedata[2:0];
          end
        end
        `PDE_OFF_ANSEL: begin
          if (avs_byteenable[0]) begin
            st_next.ansel = avs_writedata[6:0];
          end
        end
        default: begin
        end
      endcase
    end
    // Hardware events after software so they win: in_full and overrun sets beat clears, rd_start clears out_full
    if (wr_start && st_reg.in_full) begin
      st_next.overrun = 1'b1;
    end
    if (wr_end) begin
      st_next.slave_in = d_sync;
      st_next.in_full = 1'b1;
      st_next.flag = 1'b1;
    end
    if (rd_start) begin
      st_next.out_full = 1'b0;
    end
    if (rd_end) begin
      st_next.flag = 1'b1;
    end
    // Port D drive: slave mode drives only during an external read
    if (slave_active) begin
      st_next.d_oe = reading ? 8'hFF : 8'h00;
      st_next.d_out = st_reg.d_lat;
    end else begin
      st_next.d_oe = ~st_reg.d_dir;
      st_next.d_out = st_reg.d_lat;
      for (int i = 0; i < 4; i++) begin
        if (pwm_out_en[i]) begin
          st_next.d_oe[4 + i] = 1'b1;
          st_next.d_out[4 + i] = pwm_out[i];
        end
      end
      if (capture_compare_out_en && !pwm_out_en[0]) begin
        st_next.d_oe[4] = 1'b1;
        st_next.d_out[4] = capture_compare_out;
      end
    end
    // Port E drive; strobes are inputs in slave mode
    st_next.e_oe = (slave_active || SMALL_PACKAGE) ? 3'h0 : ~st_reg.e_dir;
    st_next.e_out = st_reg.e_lat;
    for (int j = 0; j < 2; j++) begin
      if (comparator_out_en[j] && !slave_active && !SMALL_PACKAGE) begin
        st_next.e_oe[1 + j] = 1'b1;
        st_next.e_out[1 + j] = comparator_out[j];
      end
    end
    st_next.d_dig = d_rd;
    // Reset pin level passes through only in reset mode
    st_next.ext_rst = external_reset_pin_enable ? re3_sync : 1'b1;
  end
  // State register; reset puts pins in input and port D bits 3:0 and port E bits 2:0 in analog
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      st_reg <= '0;
      st_reg.d_dir <= `PDE_RST_D_DIR;
      st_reg.e_dir <= `PDE_RST_E_DIR;
      st_reg.ansel <= `PDE_RST_ANSEL;
      st_reg.d_lat <= `PDE_RST_LAT;
      st_reg.ext_rst <= 1'b1;
    end else begin
      st_reg <= st_next;
    end
  end
  // Outputs straight from flip-flops, except avs_waitrequest which also decodes the request
  assign avs_readdata = st_reg.rdata;
  assign avs_waitrequest = (avs_read || avs_write) && !st_reg.ack;
  assign port_d_out = st_reg.d_out;
  assign port_d_oe = st_reg.d_oe;
  assign port_e_out = st_reg.e_out;
  assign port_e_oe = st_reg.e_oe;
  assign slave_port_interrupt_flag = st_reg.flag;
  assign port_d_digital_in = st_reg.d_dig;
  assign external_reset_input = st_reg.ext_rst;
endmodule

// >>> test/pde_port_props.sv
// Concurrent checks on the port D/E block pins and bus
`timescale 1ns/1ps
module pde_port_props (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst_b,
  // Bus
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic avs_waitrequest,
  input wire logic [31:0] avs_readdata,
  // Pins and overrides
  input wire logic [7:0] port_d_out,
  input wire logic [7:0] port_d_oe,
  input wire logic [2:0] port_e_oe,
  input wire logic [2:0] port_e_in,
  input wire logic pwm_multi_output,
  input wire logic [3:0] pwm_out_en,
  input wire logic [3:0] pwm_out,
  input wire logic external_reset_pin_enable,
  input wire logic external_reset_input,
  input wire logic slave_port_interrupt_flag
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_b);
  logic [4:0] cs_age_reg;
  // Cycles since chip select was last low; a flag needs a recent window
  always_ff @(posedge sys_clk) begin
    if (!rst_b || !port_e_in[2]) cs_age_reg <= 5'h00;
    else if (cs_age_reg != 5'h1F) cs_age_reg <= cs_age_reg + 5'h01;
  end
  // ==========================================================
  // Properties
  sequence s_req_wait;
    (avs_read || avs_write) && avs_waitrequest;
  endsequence
  sequence s_multi_pwm;
    (pwm_multi_output && pwm_out_en[3]) [*2];
  endsequence
  property p_one_wait; s_req_wait |=> !avs_waitrequest; endproperty
  property p_idle_nowait; !(avs_read || avs_write) |-> !avs_waitrequest; endproperty
  property p_reset_inputs;
    $rose(rst_b) |-> port_d_oe == 8'h00 && port_e_oe == 3'h0 && external_reset_input;
  endproperty
  property p_upper_zero; avs_read && !avs_waitrequest |-> avs_readdata[31:8] == 24'h00_0000;
  endproperty
  property p_flag_pulse; slave_port_interrupt_flag |=> !slave_port_interrupt_flag; endproperty
  property p_flag_cause; slave_port_interrupt_flag |-> cs_age_reg < 5'h0C; endproperty
  property p_ext_off; !external_reset_pin_enable [*2] |-> external_reset_input; endproperty
  property p_pwm_d;
    s_multi_pwm |-> port_d_oe[7] && port_d_out[7] == $past(pwm_out[3]);
  endproperty
  a_one_wait: assert property (p_one_wait) else $error("wait longer than one cycle");
  a_idle_nowait: assert property (p_idle_nowait) else $error("wait without request");
  a_reset_inputs: assert property (p_reset_inputs) else $error("pins not inputs at reset");
  a_upper_zero: assert property (p_upper_zero) else $error("upper read bits set");
  a_flag_pulse: assert property (p_flag_pulse) else $error("flag longer than one cycle");
  a_flag_cause: assert property (p_flag_cause) else $error("flag without window");
  a_ext_off: assert property (p_ext_off) else $error("reset input active while off");
  a_pwm_d: assert property (p_pwm_d) else $error("pwm output d not on pin 7");
endmodule
bind pde_port pde_port_props u_props (.sys_clk(sys_clk), .rst_b(rst_b), .avs_read(avs_read),
  .avs_write(avs_write), .avs_waitrequest(avs_waitrequest), .avs_readdata(avs_readdata),
  .port_d_out(port_d_out), .port_d_oe(port_d_oe), .port_e_oe(port_e_oe), .port_e_in(port_e_in),
  .pwm_multi_output(pwm_multi_output), .pwm_out_en(pwm_out_en), .pwm_out(pwm_out),
  .external_reset_pin_enable(external_reset_pin_enable),
  .external_reset_input(external_reset_input),
  .slave_port_interrupt_flag(slave_port_interrupt_flag));

// >>> test/pde_pins.sv
// Far-side circuitry model resolving each port pin level
`timescale 1ns/1ps
module pde_pins (
  // Clock
  input wire logic sys_clk,
  // Design drive
  input wire logic [10:0] dev_out,
  input wire logic [10:0] dev_oe,
  // Far side drive
  input wire logic [10:0] ext_val,
  input wire logic [10:0] ext_en,
  // Resolved levels
  output logic [10:0] pin
);
  logic [10:0] last_reg = 11'h000;
  // No pulls: a floating line shows the inverse of its last level
  always_comb begin
    for (int i = 0; i < 11; i++) begin
      pin[i] = dev_oe[i] ? dev_out[i] : (ext_en[i] ? ext_val[i] : ~last_reg[i]);
    end
  end
  // Last level memory
  always @(posedge sys_clk) begin
    last_reg <= pin;
  end
endmodule

// >>> test/tb_pde_port.sv
// Self-checking testbench for the port D/E block
`timescale 1ns/1ps
module tb_pde_port;
  logic sys_clk, rst_b, avs_read, avs_write, avs_waitrequest, ext_rst_en, input_only_pin;
  logic pwm_multi, flag, ext_reset_in, seen;
  logic [5:0] avs_address;
  logic [31:0] avs_writedata, avs_readdata;
  logic [3:0] avs_byteenable, pwm_en, pwm_val;
  logic [7:0] d_out, d_oe, d_dig, v;
  logic [2:0] e_out, e_oe;
  logic [10:0] ext_val, ext_en, pin;
  int mismatches, total_checks;
  pde_port uut (.sys_clk(sys_clk), .rst_b(rst_b), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .port_d_in(pin[7:0]), .port_d_out(d_out),
    .port_d_oe(d_oe), .port_e_in(pin[10:8]), .port_e_out(e_out), .port_e_oe(e_oe),
    .input_only_pin(input_only_pin), .external_reset_pin_enable(ext_rst_en),
    .pwm_multi_output(pwm_multi), .pwm_out_en(pwm_en), .pwm_out(pwm_val),
    .capture_compare_out_en(1'b0), .capture_compare_out(1'b0), .comparator_out_en(2'b00),
    .comparator_out(2'b00), .slave_port_interrupt_flag(flag), .port_d_digital_in(d_dig),
    .external_reset_input(ext_reset_in));
  pde_pins u_pins (.sys_clk(sys_clk), .dev_out({e_out, d_out}), .dev_oe({e_oe, d_oe}),
    .ext_val(ext_val), .ext_en(ext_en), .pin(pin));
  // ==========================================================
  // Shared tasks
  task check(input logic [31:0] s, input logic [31:0] e);
    total_checks++;
    if (s !== e) begin
      mismatches++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  // One Avalon access; raised after a rising edge, held until waitrequest is sampled low
  task bus(input logic w, input logic [5:0] a, input logic [7:0] wd, input logic [3:0] be);
    int n;
    @(posedge sys_clk);
    avs_address <= a;
    avs_write <= w;
    avs_read <= !w;
    avs_writedata <= {24'h00_0000, wd};
    avs_byteenable <= be;
    n = 0;
    do begin
      @(posedge sys_clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 100);
    // Read data taken at the same edge that sees waitrequest low
    v = avs_readdata[7:0];
    if (avs_waitrequest !== 1'b0) mismatches++;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    // Let registered pin outputs follow the write, then look mid-cycle
    @(posedge sys_clk);
    @(negedge sys_clk);
  endtask
  task wr(input logic [5:0] a, input logic [7:0] d); bus(1'b1, a, d, 4'hF); endtask
  task rc(input logic [5:0] a, input logic [7:0] e);
    bus(1'b0, a, 8'h00, 4'hF);
    check({24'h00_0000, v}, {24'h00_0000, e});
  endtask
  // Strobe window on port E; samples port D drive mid-window
  task window(input logic [2:0] e);
    @(posedge sys_clk);
    ext_val[10:8] <= e;
    repeat (6) @(posedge sys_clk);
    @(negedge sys_clk);
    v = d_oe;
    @(posedge sys_clk);
    ext_val[10:8] <= 3'h7;
    seen = 1'b0;
    repeat (20) begin
      @(negedge sys_clk);
      if (flag === 1'b1) seen = 1'b1;
    end
    @(posedge sys_clk);
  endtask
  // ==========================================================
  // Scenarios
  task t_reset;
    check(d_oe, 8'h00);
    rc(6'h08, 8'hFF);
    rc(6'h0C, 8'h07);
    rc(6'h18, 8'h7F);
    rc(6'h1C, 8'h00);
  endtask
  task t_gpio;
    wr(6'h04, 8'hA5);
    wr(6'h08, 8'hF0);
    check(d_oe, 8'h0F);
    check(d_out & d_oe, 8'h05);
    rc(6'h00, 8'hF0);
    rc(6'h10, 8'h08);
    wr(6'h18, 8'h00);
    repeat (4) @(posedge sys_clk);
    rc(6'h00, 8'hF5);
    check(d_dig, 8'hF5);
    rc(6'h10, 8'h0F);
    wr(6'h00, 8'h3C);
    bus(1'b1, 6'h04, 8'hFF, 4'h0);
    rc(6'h04, 8'h3C);
    wr(6'h14, 8'h05);
    wr(6'h0C, 8'h00);
    check({e_oe, e_out & e_oe}, 6'h3D);
    wr(6'h0C, 8'h07);
    wr(6'h08, 8'hFF);
  endtask
  task t_slave;
    @(posedge sys_clk);
    ext_val[7:0] <= 8'h5A;
    wr(6'h0C, 8'h17);
    window(3'h1);
    check(seen, 1'b1);
    rc(6'h0C, 8'h97);
    window(3'h1);
    rc(6'h0C, 8'hB7);
    rc(6'h00, 8'h5A);
    rc(6'h0C, 8'h37);
    wr(6'h0C, 8'h17);
    rc(6'h0C, 8'h17);
    wr(6'h04, 8'h33);
    rc(6'h0C, 8'h57);
    @(posedge sys_clk);
    ext_en[7:0] <= 8'h00;
    window(3'h2);
    check(v, 8'hFF);
    check(seen, 1'b1);
    ext_en[7:0] <= 8'hFF;
    rc(6'h0C, 8'h17);
  endtask
  task t_multi;
    @(posedge sys_clk);
    pwm_multi <= 1'b1;
    pwm_en <= 4'hF;
    pwm_val <= 4'hA;
    window(3'h1);
    check(seen, 1'b0);
    check({d_oe[7:4], d_out[7:4]}, 8'hFA);
    rc(6'h0C, 8'h17);
    @(posedge sys_clk);
    ext_rst_en <= 1'b1;
    input_only_pin <= 1'b0;
    repeat (5) @(posedge sys_clk);
    check(ext_reset_in, 1'b0);
  endtask
  // ==========================================================
  // Verdict and run control
  task wrap_up;
    if (mismatches == 0 && total_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  initial begin
    sys_clk = 1'b0;
    forever #2 sys_clk = ~sys_clk;
  end
  // Watchdog, far beyond the few hundred cycles the scenarios need
  initial begin
    #200000;
    mismatches++;
    wrap_up;
  end
  initial begin
    rst_b = 1'b0;
    {avs_read, avs_write, pwm_multi, ext_rst_en} = 4'h0;
    {avs_address, avs_writedata, avs_byteenable} = 42'h0;
    {pwm_en, pwm_val} = 8'h00;
    input_only_pin = 1'b1;
    ext_val = 11'h7FF;
    ext_en = 11'h7FF;
    mismatches = 0;
    total_checks = 0;
    repeat (12) @(posedge sys_clk);
    rst_b <= 1'b1;
    @(posedge sys_clk);
    t_reset;
    t_gpio;
    t_slave;
    t_multi;
    wrap_up;
  end
endmodule
